// [rtl/vicb_defines.vh]
/*
 * Offsets, field positions, reset values and timing for the virtual
 * interrupt control block field loader. Included by rtl/vicb_fields.v.
 */
`ifndef VICB_DEFINES_VH
`define VICB_DEFINES_VH

// Register byte offsets (64-bit registers low word at offset, high at +4; CMD, STATUS, TPRW, PAW are single words)
`define VICB_OFF_VIC_LO      8'h60
`define VICB_OFF_VIC_HI      8'h64
`define VICB_OFF_BAR_LO      8'h98
`define VICB_OFF_BAR_HI      8'h9c
`define VICB_OFF_BPP_LO      8'he0
`define VICB_OFF_BPP_HI      8'he4
`define VICB_OFF_LTP_LO      8'hf0
`define VICB_OFF_LTP_HI      8'hf4
`define VICB_OFF_PTP_LO      8'hf8
`define VICB_OFF_PTP_HI      8'hfc
`define VICB_OFF_CMD         8'h00
`define VICB_OFF_STATUS      8'h04
`define VICB_OFF_TPRW        8'h08
`define VICB_OFF_PAW         8'h0c

// Control word fields
`define VICB_TPR_LSB         0
`define VICB_TPR_MSB         3
`define VICB_IRQ_BIT         8
`define VICB_PRIO_LSB        16
`define VICB_PRIO_MSB        19
`define VICB_IGN_BIT         20
`define VICB_MASK_BIT        24
`define VICB_EN_BIT          31
`define VICB_VEC_LSB         32
`define VICB_VEC_MSB         39

// Pointer fields
`define VICB_PTR_LSB         12
`define VICB_PTR_MSB         51
`define VICB_IDX_LSB         0
`define VICB_IDX_MSB         7

// Writable masks of each register (reserved bits stay zero)
`define VICB_VIC_MASK        64'h0000_00ff_811f_010f
`define VICB_PTR_MASK        64'h000f_ffff_ffff_f000
`define VICB_PTP_MASK        64'h000f_ffff_ffff_f0ff

// Command bits
`define VICB_CMD_ENTRY       0
`define VICB_CMD_EXIT        1

// Reset values
`define VICB_RST_REG         64'h0000_0000_0000_0000
`define VICB_RST_PAW         6'h34

// Cycles from entry command to load/exit decision
`define VICB_CHECK_CYCLES    2

`endif

// [rtl/vicb_fields.v]
/*
 * Guest control block fields for accelerated virtual interrupt delivery,
 * one virtual processor. Holds the control word and four pointer fields,
 * checks pointers at guest entry, writes state back at guest exit.
 * Assumes a single-cycle register port master on ref_clk and synchronous
 * guest events (task priority writes, entry/exit commands) on the same clock.
 */
// The strobed register port was left to the implementer.
`default_nettype none
`include "vicb_defines.vh"

module vicb_fields #(
   parameter MAX_PA_BITS = 52
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Guest events from the core
   input  wire        guest_tpr_wr,
   input  wire [7:0]  guest_tpr_data,
   input  wire        guest_pending_now,
   // Decoded fields in force for the running guest
   output reg         guest_running,
   output reg         entry_done,
   output reg         entry_fault,
   output reg         accel_irq_enable,
   output reg  [3:0]  virtual_task_priority,
   output reg         virtual_irq_pending,
   output reg  [3:0]  virtual_irq_priority,
   output reg         ignore_priority_threshold,
   output reg         virtual_irq_masking,
   output reg  [7:0]  virtual_irq_vector,
   output reg         deliver_allowed,
   output reg  [7:0]  physical_id_last_index
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_CHECK = 2'h1;
   localparam ST_RUN   = 2'h2;

   // Ceiling for the software-set implemented address width
   localparam [5:0] PA_MAX = MAX_PA_BITS[5:0];

   reg [63:0] vic_q;
   reg [63:0] bar_q;
   reg [63:0] bpp_q;
   reg [63:0] ltp_q;
   reg [63:0] ptp_q;
   reg [5:0]  paw_q;
   reg [1:0]  state_q;
   reg [1:0]  cnt_q;
   reg        fault_seen_q;

   // Merge a 32-bit half-write into a 64-bit field under its writable mask
   function [63:0] merge;
      input [63:0] old;
      input [31:0] data;
      input        hi;
      input [63:0] mask;
      reg   [63:0] nv;
      begin
         nv = hi ? {data, old[31:0]} : {old[63:32], data};
         merge = nv & mask;
      end
   endfunction

   // True when a pointer has address bits at or above the implemented width
   function out_of_range;
      input [63:0] ptr;
      input [5:0]  width;
      reg   [63:0] lim;
      begin
         lim = 64'h1 << width;
         out_of_range = (ptr[`VICB_PTR_MSB:`VICB_PTR_LSB] >= lim[63:12]);
      end
   endfunction

   wire start = reg_wr && (reg_addr == `VICB_OFF_CMD) && reg_wdata[`VICB_CMD_ENTRY];
   wire leave = reg_wr && (reg_addr == `VICB_OFF_CMD) && reg_wdata[`VICB_CMD_EXIT];
   wire any_bad = out_of_range(bar_q, paw_q) | out_of_range(bpp_q, paw_q) |
                  out_of_range(ltp_q, paw_q) | out_of_range(ptp_q, paw_q);
   wire [3:0] tpr_cur = vic_q[`VICB_TPR_MSB:`VICB_TPR_LSB];

   always @(posedge ref_clk) begin
      if (rst) begin
         vic_q        <= `VICB_RST_REG;
         bar_q        <= `VICB_RST_REG;
         bpp_q        <= `VICB_RST_REG;
         ltp_q        <= `VICB_RST_REG;
         ptp_q        <= `VICB_RST_REG;
         paw_q        <= `VICB_RST_PAW;
         state_q      <= ST_IDLE;
         cnt_q        <= 2'h0;
         fault_seen_q <= 1'b0;
         guest_running <= 1'b0;
         entry_done   <= 1'b0;
         entry_fault  <= 1'b0;
         accel_irq_enable <= 1'b0;
         virtual_task_priority <= 4'h0;
         virtual_irq_pending <= 1'b0;
         virtual_irq_priority <= 4'h0;
         ignore_priority_threshold <= 1'b0;
         virtual_irq_masking <= 1'b0;
         virtual_irq_vector <= 8'h00;
         deliver_allowed <= 1'b0;
         physical_id_last_index <= 8'h00;
      end else begin
         entry_done  <= 1'b0;
         entry_fault <= 1'b0;
         // Software edits the block only while no guest runs on it
         if (reg_wr && state_q == ST_IDLE) begin
            case (reg_addr)
               `VICB_OFF_VIC_LO: vic_q <= merge(vic_q, reg_wdata, 1'b0, `VICB_VIC_MASK);
               `VICB_OFF_VIC_HI: vic_q <= merge(vic_q, reg_wdata, 1'b1, `VICB_VIC_MASK);
               `VICB_OFF_BAR_LO: bar_q <= merge(bar_q, reg_wdata, 1'b0, `VICB_PTR_MASK);
               `VICB_OFF_BAR_HI: bar_q <= merge(bar_q, reg_wdata, 1'b1, `VICB_PTR_MASK);
               `VICB_OFF_BPP_LO: bpp_q <= merge(bpp_q, reg_wdata, 1'b0, `VICB_PTR_MASK);
               `VICB_OFF_BPP_HI: bpp_q <= merge(bpp_q, reg_wdata, 1'b1, `VICB_PTR_MASK);
               `VICB_OFF_LTP_LO: ltp_q <= merge(ltp_q, reg_wdata, 1'b0, `VICB_PTR_MASK);
               `VICB_OFF_LTP_HI: ltp_q <= merge(ltp_q, reg_wdata, 1'b1, `VICB_PTR_MASK);
               `VICB_OFF_PTP_LO: ptp_q <= merge(ptp_q, reg_wdata, 1'b0, `VICB_PTP_MASK);
               `VICB_OFF_PTP_HI: ptp_q <= merge(ptp_q, reg_wdata, 1'b1, `VICB_PTP_MASK);
               // Below 13 bits not even the first page above zero would be legal
               `VICB_OFF_PAW: paw_q <= (reg_wdata[5:0] > PA_MAX) ? PA_MAX :
                                        ((reg_wdata[5:0] < 6'h0d) ? 6'h0d : reg_wdata[5:0]);
               default: ;
            endcase
         end
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q      <= ST_CHECK;
                  cnt_q        <= 2'h0;
                  fault_seen_q <= 1'b0;
               end
            end
            ST_CHECK: begin
               fault_seen_q <= fault_seen_q | any_bad;
               if (cnt_q == `VICB_CHECK_CYCLES - 1) begin
                  entry_done <= 1'b1;
                  if (fault_seen_q | any_bad) begin
                     // Failed entry is an immediate exit; nothing is loaded
                     entry_fault <= 1'b1;
                     state_q     <= ST_IDLE;
                  end else begin
                     state_q <= ST_RUN;
                     guest_running <= 1'b1;
                     accel_irq_enable <= vic_q[`VICB_EN_BIT];
                     virtual_task_priority <= tpr_cur;
                     virtual_irq_masking <= vic_q[`VICB_MASK_BIT];
                     physical_id_last_index <= ptp_q[`VICB_IDX_MSB:`VICB_IDX_LSB];
                     if (vic_q[`VICB_EN_BIT]) begin
                        // Injection fields are disabled under acceleration
                        virtual_irq_pending <= 1'b0;
                        virtual_irq_priority <= 4'h0;
                        ignore_priority_threshold <= 1'b0;
                        virtual_irq_vector <= 8'h00;
                        deliver_allowed <= 1'b0;
                     end else begin
                        virtual_irq_pending <= vic_q[`VICB_IRQ_BIT];
                        virtual_irq_priority <= vic_q[`VICB_PRIO_MSB:`VICB_PRIO_LSB];
                        ignore_priority_threshold <= vic_q[`VICB_IGN_BIT];
                        virtual_irq_vector <= vic_q[`VICB_VEC_MSB:`VICB_VEC_LSB];
                        deliver_allowed <= vic_q[`VICB_IRQ_BIT] &&
                           (vic_q[`VICB_IGN_BIT] ||
                            vic_q[`VICB_PRIO_MSB:`VICB_PRIO_LSB] > tpr_cur);
                     end
                  end
               end else begin
                  cnt_q <= cnt_q + 2'h1;
               end
            end
            ST_RUN: begin
               if (guest_tpr_wr) begin
                  virtual_task_priority <= guest_tpr_data[7:4];
                  deliver_allowed <= virtual_irq_pending &&
                     (ignore_priority_threshold || virtual_irq_priority > guest_tpr_data[7:4]);
               end
               if (leave) begin
                  state_q <= ST_IDLE;
                  guest_running <= 1'b0;
                  deliver_allowed <= 1'b0;
                  vic_q[`VICB_TPR_MSB:`VICB_TPR_LSB] <=
                     guest_tpr_wr ? guest_tpr_data[7:4] : virtual_task_priority;
                  vic_q[`VICB_IRQ_BIT] <= guest_pending_now;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped addresses read zero
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `VICB_OFF_VIC_LO: reg_rdata <= vic_q[31:0];
            `VICB_OFF_VIC_HI: reg_rdata <= vic_q[63:32];
            `VICB_OFF_BAR_LO: reg_rdata <= bar_q[31:0];
            `VICB_OFF_BAR_HI: reg_rdata <= bar_q[63:32];
            `VICB_OFF_BPP_LO: reg_rdata <= bpp_q[31:0];
            `VICB_OFF_BPP_HI: reg_rdata <= bpp_q[63:32];
            `VICB_OFF_LTP_LO: reg_rdata <= ltp_q[31:0];
            `VICB_OFF_LTP_HI: reg_rdata <= ltp_q[63:32];
            `VICB_OFF_PTP_LO: reg_rdata <= ptp_q[31:0];
            `VICB_OFF_PTP_HI: reg_rdata <= ptp_q[63:32];
            `VICB_OFF_STATUS: reg_rdata <= {28'h0000000, fault_seen_q, state_q, guest_running};
            `VICB_OFF_PAW:    reg_rdata <= {26'h0, paw_q};
            default:          reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // vicb_fields
`default_nettype wire

// [verif/tb_virq_ctrl_block_fields.sv]
/* Self-checking bench for vicb_fields: register port, entry, exit.
   Assumes the design header is on the include path. */
`default_nettype none
`include "vicb_defines.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_virq_ctrl_block_fields;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, guest_tpr_wr = 0;
   logic        guest_pending_now = 0, rd_prev = 0;
   logic [7:0]  reg_addr = 8'h00, guest_tpr_data = 8'h00;
   logic [31:0] reg_wdata = 32'h0, x, d;
   logic [15:0] r = 16'h101f;
   logic [29:0] e;
   logic [31:0] rq[$];
   logic [29:0] eq[$];
   int          error_cnt = 0, tests_run = 0, cyc = 0;
   logic [7:0]  offs[10] = '{8'h60, 8'h64, 8'h98, 8'h9c, 8'he0, 8'he4, 8'hf0, 8'hf4, 8'hf8, 8'hfc};
   logic [7:0]  pa[4] = '{8'h98, 8'he0, 8'hf0, 8'hf8};
   wire [31:0]  reg_rdata;
   wire         guest_running, entry_done, entry_fault, accel_irq_enable, virtual_irq_pending;
   wire         ignore_priority_threshold, virtual_irq_masking, deliver_allowed;
   wire [3:0]   virtual_task_priority, virtual_irq_priority;
   wire [7:0]   virtual_irq_vector, physical_id_last_index;
   wire [29:0]  fld = {entry_fault, accel_irq_enable, virtual_task_priority, virtual_irq_pending,
      virtual_irq_priority, ignore_priority_threshold, virtual_irq_masking, virtual_irq_vector,
      physical_id_last_index, deliver_allowed};
   vicb_fields u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .guest_tpr_wr, .guest_tpr_data, .guest_pending_now, .guest_running, .entry_done,
      .entry_fault, .accel_irq_enable, .virtual_task_priority, .virtual_irq_pending,
      .virtual_irq_priority, .ignore_priority_threshold, .virtual_irq_masking,
      .virtual_irq_vector, .deliver_allowed, .physical_id_last_index);
   always #4 ref_clk = ~ref_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] msk(input logic [7:0] a);
      logic [63:0] m;
      m = (a < 8'h98) ? `VICB_VIC_MASK : (a >= 8'hf8) ? `VICB_PTP_MASK : `VICB_PTR_MASK;
      return a[2] ? m[63:32] : m[31:0];
   endfunction
   task report_and_stop;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Strobes drop for one cycle between transfers so no signal is set twice at one edge
   task wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v);
      rq.push_back(v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task task_priority_register(input logic [7:0] v);
      guest_tpr_data <= v;
      guest_tpr_wr <= 1'b1;
      @(posedge ref_clk);
      guest_tpr_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task ent(input logic [29:0] v);
      eq.push_back(v);
      wr(8'h00, 32'h1);
      repeat (3) @(posedge ref_clk);
   endtask
   always @(negedge ref_clk) begin
      if (rd_prev) begin
         x = rq.pop_front();
         `CHK("rdata", x, reg_rdata)
      end
      if (entry_done !== 1'b0) begin
         e = eq.pop_front();
         if (e[29])
            `CHK("fault", 1'b1, entry_fault)
         else
            `CHK("fields", e, fld)
      end
      rd_prev = reg_rd;
   end
   // Whole run needs under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      foreach (offs[i]) rd(offs[i], 32'h0);
      rd(8'h50, 32'h0);
      foreach (offs[i]) begin
         r = lfsr(r);
         d = {lfsr(r), r};
         wr(offs[i], d);
         rd(offs[i], d & msk(offs[i]));
      end
      wr(8'h50, 32'hffff_ffff);
      rd(8'h50, 32'h0);
      wr(8'h0c, 32'h28);
      // Bench as hypervisor: page-aligned pointers into write-back memory
      foreach (pa[i]) begin
         wr(pa[i], (i == 3) ? 32'h4007 : (i + 1) << 12);
         wr(pa[i] + 8'h04, 32'h80);
      end
      wr(8'h60, 32'h0105_0103);
      wr(8'h64, 32'h41);
      ent({2'b00, 4'h3, 1'b1, 4'h5, 1'b0, 1'b1, 8'h41, 8'h07, 1'b1});
      task_priority_register(8'h7c);
      wr(8'h60, 32'h0);
      rd(8'h60, 32'h0105_0103);
      wr(8'h00, 32'h2);
      rd(8'h60, 32'h0105_0007);
      // Nested paging is taken as on for this accelerated guest
      wr(8'h60, 32'h8115_0002);
      guest_pending_now <= 1'b1;
      ent({2'b01, 4'h2, 1'b0, 4'h0, 1'b0, 1'b1, 8'h00, 8'h07, 1'b0});
      task_priority_register(8'h90);
      wr(8'h00, 32'h2);
      rd(8'h60, 32'h8115_0109);
      // Ignore bit lets a priority below the task priority through
      wr(8'h60, 32'h0011_0106);
      ent({2'b00, 4'h6, 1'b1, 4'h1, 1'b1, 1'b0, 8'h41, 8'h07, 1'b1});
      wr(8'h00, 32'h2);
      rd(8'h60, 32'h0011_0106);
      foreach (pa[i]) begin
         wr(pa[i] + 8'h04, 32'h100);
         ent({1'b1, 29'h0});
         wr(pa[i] + 8'h04, 32'h80);
      end
      report_and_stop();
   end
endmodule // tb_virq_ctrl_block_fields
`default_nettype wire

// [verif/vicb_fields_chk.sv]
/* Port checker for vicb_fields, bound to every instance.
   Assumes ref_clk with synchronous active-high rst. */
`default_nettype none
module vicb_fields_chk #(parameter MAX_PA_BITS = 52) (
   // Clock, reset and register port
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Guest events and decoded fields
   input wire logic        guest_tpr_wr,
   input wire logic [7:0]  guest_tpr_data,
   input wire logic        guest_running,
   input wire logic        entry_done,
   input wire logic        entry_fault,
   input wire logic        accel_irq_enable,
   input wire logic [3:0]  virtual_task_priority,
   input wire logic        virtual_irq_pending,
   input wire logic [3:0]  virtual_irq_priority,
   input wire logic        ignore_priority_threshold,
   input wire logic [7:0]  virtual_irq_vector,
   input wire logic        deliver_allowed
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire       cmd_wr = reg_wr && reg_addr == 8'h00;
   wire [3:0] tpr_hi = guest_tpr_data[7:4];
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data present without a read");
   a_entry_two_cycles: assert property (cmd_wr && reg_wdata[0] && !guest_running |-> ##3 entry_done)
      else $error("entry check did not finish on time");
   a_done_one_pulse: assert property (entry_done |=> !entry_done)
      else $error("entry done longer than one cycle");
   a_fault_blocks_run: assert property (entry_done |-> guest_running == !entry_fault)
      else $error("guest running disagrees with entry fault");
   a_accel_zeroes_inj: assert property (accel_irq_enable |-> !virtual_irq_pending &&
      virtual_irq_priority == 4'h0 && !ignore_priority_threshold && virtual_irq_vector == 8'h00)
      else $error("injection fields live while accelerated");
   a_deliver_by_prio: assert property (guest_running && $stable(guest_running) &&
      $stable(virtual_task_priority) |-> deliver_allowed == (virtual_irq_pending &&
      (ignore_priority_threshold || virtual_irq_priority > virtual_task_priority)))
      else $error("delivery decision wrong");
   a_tpr_copy_upper: assert property (guest_running && guest_tpr_wr && !cmd_wr |=>
      virtual_task_priority == $past(tpr_hi))
      else $error("task priority not copied from guest write");
   a_exit_stops_run: assert property (guest_running && cmd_wr && reg_wdata[1] |=>
      !guest_running && !deliver_allowed)
      else $error("exit did not stop the guest");
   c_entry_ok: cover property (entry_done && !entry_fault);
   c_entry_fault: cover property (entry_fault);
   c_tpr_running: cover property (guest_running && guest_tpr_wr);
   c_ignore_deliver: cover property (entry_done && ignore_priority_threshold && deliver_allowed);
endmodule // vicb_fields_chk
bind vicb_fields vicb_fields_chk #(.MAX_PA_BITS(MAX_PA_BITS)) u_chk (.ref_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .guest_tpr_wr, .guest_tpr_data, .guest_running,
   .entry_done, .entry_fault, .accel_irq_enable, .virtual_task_priority, .virtual_irq_pending,
   .virtual_irq_priority, .ignore_priority_threshold, .virtual_irq_vector, .deliver_allowed);
`default_nettype wire
